//--- sim/fpc_param_check_assertions.sv
`timescale 1ns/100ps
// Watches the call interface of the parameter checker
module fpc_param_check_assertions (
	input wire clk_sys, input wire srst, input wire start, input wire op_sel,
	input wire [31:0] src_addr, input wire [31:0] dst_addr, input wire [31:0] erase_block_select,
	input wire flash_write_enable_in, input wire flash_error_state, input wire flash_go, input wire flash_op,
	input wire [15:0] block_strobe, input wire flash_done, input wire flash_fail,
	input wire [7:0] pass_fail_result, input wire busy
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// A taken call, and a call that cannot write at all
	wire tk = start && !busy;
	wire mde = !flash_write_enable_in || flash_error_state;
	wire [3:0] blk_n = erase_block_select[3:0];
	sequence s_go; busy ##1 flash_go; endsequence
	chk_mode_err: assert property (tk && mde |=> pass_fail_result[6] && pass_fail_result[0] && !flash_go)
		else $error("mode flag wrong");
	chk_src_err: assert property (tk && !op_sel && !mde && src_addr < 32'h00020000 |=> pass_fail_result[2])
		else $error("source flag wrong");
	chk_dst_err: assert property (tk && !op_sel && !mde && (dst_addr > 32'h0001FFFF || dst_addr[6:0] != 7'h00)
		|=> pass_fail_result[1] && pass_fail_result[0]) else $error("destination flag wrong");
	chk_erase_go: assert property (tk && op_sel && !mde && erase_block_select < 32'h10 |=> s_go)
		else $error("erase not launched");
	chk_bad_blk: assert property (tk && op_sel && erase_block_select > 32'h0F |=> pass_fail_result[0] && !busy)
		else $error("bad block accepted");
	chk_blk_map: assert property (tk && op_sel && !mde && erase_block_select < 32'h10 |=>
		(block_strobe == (16'h0001 << $past(blk_n))) ##1 (flash_go && block_strobe == (16'h0001 << $past(blk_n, 2))))
		else $error("block strobe wrong");
	chk_prog_strb: assert property (flash_go && !flash_op |-> block_strobe == 16'h0000)
		else $error("strobe during program");
	chk_end_result: assert property (flash_done && busy && $past(busy) |=> pass_fail_result == {2'h0, $past(flash_fail),
		4'h0, $past(flash_fail)} && !busy) else $error("end result wrong");
endmodule // fpc_param_check_assertions

bind fpc_param_check fpc_param_check_assertions chk (.*);

//--- sim/fpc_param_check_test.sv
`timescale 1ns/100ps
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", n, e, g); end end
module fpc_param_check_test;
	reg clk_sys = 0, srst = 1, start = 0, op_sel = 0, flash_write_enable_in = 1, flash_error_state = 0;
	reg flash_done = 0, flash_fail = 0;
	reg [31:0] src_addr = 0, dst_addr = 0, erase_block_select = 0;
	wire flash_go, flash_op, busy;
	wire [15:0] block_strobe;
	wire [7:0] pass_fail_result;
	integer miscompares = 0, checked = 0, i;
	always #50 clk_sys = ~clk_sys;
	fpc_param_check dut (.*);
	task final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// One call; parameters stay put until the next call
	task call(input o, input [31:0] s, input [31:0] d, input [31:0] b);
		@(negedge clk_sys); op_sel = o; src_addr = s; dst_addr = d; erase_block_select = b; start = 1;
		@(negedge clk_sys); start = 0;
	endtask
	// Engine side: bounded wait for launch, then finish with the given outcome
	task run(input f, input [15:0] sb, input [7:0] r);
		integer n;
		n = 0;
		while (flash_go !== 1'b1 && n < 20) begin @(negedge clk_sys); n++; end
		`CHK("launch", 1'b1, flash_go)
		`CHK("strobe", sb, block_strobe)
		`CHK("op", op_sel, flash_op)
		flash_done = 1; flash_fail = f; @(negedge clk_sys); flash_done = 0;
		`CHK("go_pulse", 1'b0, flash_go)
		`CHK("strobe_end", 16'h0000, block_strobe)
		`CHK("busy_end", 1'b0, busy)
		@(negedge clk_sys);
		`CHK("result", r, pass_fail_result)
	endtask
	// Outputs after the opening reset, then a reset in the middle of an erase
	task t_reset;
		`CHK("rst_result", 8'h00, pass_fail_result)
		`CHK("rst_busy", 1'b0, busy)
		`CHK("rst_go", 1'b0, flash_go)
		`CHK("rst_strobe", 16'h0000, block_strobe)
		call(1, 0, 0, 7);
		`CHK("mid_busy", 1'b1, busy)
		`CHK("mid_strobe", 16'h0080, block_strobe)
		srst = 1; @(negedge clk_sys); srst = 0;
		`CHK("mid_go", 1'b0, flash_go)
		`CHK("mid_strobe0", 16'h0000, block_strobe)
		`CHK("mid_busy0", 1'b0, busy)
		`CHK("mid_op", 1'b0, flash_op)
	endtask
	// A start while busy is dropped; the launched erase finishes untouched
	task t_busy;
		call(1, 0, 0, 2);
		@(negedge clk_sys); start = 1; erase_block_select = 32'h10;
		`CHK("busy_go", 1'b1, flash_go)
		@(negedge clk_sys); start = 0; flash_done = 1; flash_fail = 0;
		`CHK("busy_drop", 8'h00, pass_fail_result)
		@(negedge clk_sys); flash_done = 0;
		`CHK("busy_res", 8'h00, pass_fail_result)
		`CHK("busy_idle", 1'b0, busy)
	endtask
	task t_mode;
		flash_write_enable_in = 0; call(1, 0, 0, 3);
		`CHK("mode_wen", 8'h41, pass_fail_result)
		flash_write_enable_in = 1; flash_error_state = 1; call(0, 32'h20000, 32'h80, 0);
		`CHK("mode_err", 8'h41, pass_fail_result)
		flash_error_state = 0;
	endtask
	task t_addr;
		call(0, 32'h100, 32'h80, 0); `CHK("src", 8'h05, pass_fail_result)
		call(0, 32'h20000, 32'h20000, 0); `CHK("dst", 8'h03, pass_fail_result)
		call(0, 32'h20000, 32'h1FF81, 0); `CHK("align", 8'h03, pass_fail_result)
		call(0, 32'h20000, 32'h1FF80, 0); run(1, 16'h0000, 8'h21);
	endtask
	// Every block in turn, the last one failing, then out-of-range numbers
	task t_erase;
		for (i = 0; i < 16; i++) begin call(1, 0, 0, i); run(i == 15, 16'h0001 << i, i == 15 ? 8'h21 : 8'h00); end
		call(1, 0, 0, 32'h10); `CHK("blk16", 8'h01, pass_fail_result)
		call(1, 0, 0, 32'h10003); `CHK("blk_hi", 8'h01, pass_fail_result)
	endtask
	initial begin repeat (3) @(negedge clk_sys); srst = 0; t_reset; t_mode; t_addr; t_erase; t_busy; final_report; end
	// The whole run needs just over a hundred cycles; the limit is 1000 cycles
	initial begin #100000; miscompares++; final_report; end
endmodule // fpc_param_check_test

//--- src/fpc_addr_check.v
`timescale 1ns/100ps
`include "fpc_regs.vh"
// Combinational address classification shared by both checks
module fpc_addr_check (
	// Addresses under test
	input  wire [31:0] src_addr,
	input  wire [31:0] dst_addr,
	// Verdicts
	output wire        src_in_flash,
	output wire        dst_bad
);
	function in_flash;
		input [31:0] a;
		begin
			in_flash = (a >= `FPC_FLASH_LO) && (a <= `FPC_FLASH_HI);
		end
	endfunction

	// Source must lie outside flash
	assign src_in_flash = in_flash(src_addr);
	// Destination must be inside flash and 128-byte aligned
	assign dst_bad = !in_flash(dst_addr)
		|| ((dst_addr[7:0] != `FPC_ALIGN_A) && (dst_addr[7:0] != `FPC_ALIGN_B));
endmodule // fpc_addr_check

//--- src/fpc_param_check.v
`timescale 1ns/100ps
`include "fpc_regs.vh"
// Notes on behaviour
// - Source address inside flash sets bit 2.
// - Destination outside flash sets bit 1.
// - Destination low byte not 00/80 sets bit 1.
// - Bit 0 reports overall pass or fail.
// - One block per erase, number 0..15.
// - Block value maps directly to block strobe.
// - Bit 6 set if write disabled or error state.
// - Bit 5 set when the erase or program failed.
module fpc_param_check (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        srst,
	// Call parameters (general registers)
	input  wire        start,
	input  wire        op_sel,
	input  wire [31:0] src_addr,
	input  wire [31:0] dst_addr,
	input  wire [31:0] erase_block_select,
	// Flash status inputs
	input  wire        flash_write_enable_in,
	input  wire        flash_error_state,
	// Flash engine handshake
	output reg         flash_go,
	output reg         flash_op,
	output reg  [15:0] block_strobe,
	input  wire        flash_done,
	input  wire        flash_fail,
	// Result
	output wire [7:0]  pass_fail_result,
	output wire        busy
);
	// One-hot sequencer states
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_RUN  = 3'b010;
	localparam [2:0] ST_WAIT = 3'b100;

	// Sequencer state
	reg  [2:0]  state_q;
	reg  [2:0]  state_d;
	// Result byte and the flags of the call being offered
	reg  [7:0]  result_q;
	reg  [7:0]  result_d;
	reg  [7:0]  call_flags;
	// Launch pulse, operation and block strobe next values
	reg         go_d;
	reg         op_d;
	reg  [15:0] strobe_d;
	// Parameter verdicts
	wire        src_in_flash;
	wire        dst_bad;
	wire        mode_err;
	wire        blk_bad;
	wire        prm_err;
	// Call and engine events
	wire        is_erase;
	wire        call_taken;
	wire        call_go;
	wire        engine_end;

	// A call is blocked outright when writes are off or protection tripped
	function mode_blocked;
		input wen;
		input prot;
		begin
			mode_blocked = !wen || prot;
		end
	endfunction

	// A program call needs its source outside and its destination inside the array
	function prog_bad;
		input src_in;
		input dst_wrong;
		begin
			prog_bad = src_in || dst_wrong;
		end
	endfunction

	// Upper half must be zero; the lower half may not pass the last block
	function blk_out_of_range;
		input [31:0] v;
		begin
			blk_out_of_range = (v[31:16] != 16'h0000) || (v[15:0] > `FPC_LAST_BLOCK);
		end
	endfunction

	// Block number to strobe line; block 0 drives bit 0
	function [15:0] blk_onehot;
		input [3:0] n;
		begin
			blk_onehot = 16'h0001 << n;
		end
	endfunction

	// Fold the engine outcome into the result byte, keeping the call flags
	function [7:0] with_outcome;
		input [7:0] r;
		input       fail;
		reg   [7:0] t;
		begin
			t = r;
			t[`FPC_BIT_EXEC_ERR]     = fail;
			t[`FPC_BIT_SUCCESS_FAIL] = fail;
			with_outcome = t;
		end
	endfunction

	// Address classification, kept in its own module
	fpc_addr_check u_addr (
		.src_addr     (src_addr),
		.dst_addr     (dst_addr),
		.src_in_flash (src_in_flash),
		.dst_bad      (dst_bad)
	);

	// Parameter verdicts; addresses only matter for programming
	assign is_erase   = (op_sel == `FPC_OP_ERASE);
	assign mode_err   = mode_blocked(flash_write_enable_in, flash_error_state);
	assign blk_bad    = blk_out_of_range(erase_block_select);
	assign prm_err    = mode_err || (is_erase ? blk_bad : prog_bad(src_in_flash, dst_bad));

	// Start is only heard in idle; a start while busy is dropped
	assign call_taken = (state_q == ST_IDLE) && start;
	assign call_go    = call_taken && !prm_err;
	assign engine_end = (state_q == ST_WAIT) && flash_done;

	// Outputs
	assign pass_fail_result = result_q;
	assign busy             = (state_q != ST_IDLE);

	// Flags of the offered call; bit 0 already reports a refused call
	always @* begin
		call_flags = `FPC_RESULT_RST;
		call_flags[`FPC_BIT_MODE_ERR] = mode_err;
		if (!is_erase) begin
			call_flags[`FPC_BIT_WDATA_ADDR_ERR] = src_in_flash;
			call_flags[`FPC_BIT_DEST_ADDR_ERR]  = dst_bad;
		end
		call_flags[`FPC_BIT_SUCCESS_FAIL] = prm_err;
	end

	// Sequencing of check, launch and completion
	always @* begin
		state_d = state_q;
		go_d    = 1'b0;
		case (state_q)
			ST_IDLE: begin
				// A refused call stays here, so nothing reaches the array
				if (call_go) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				// One cycle of strobe before the launch gives the engine a settled block
				go_d    = 1'b1;
				state_d = ST_WAIT;
			end
			ST_WAIT: begin
				// No time limit: the engine is trusted to answer
				if (flash_done) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Result byte: replaced by a taken call, completed by the engine
	always @* begin
		result_d = result_q;
		if (call_taken) begin
			result_d = call_flags;
		end else if (engine_end) begin
			result_d = with_outcome(result_q, flash_fail);
		end
	end

	// Strobe stands from the launched erase until the engine ends; exactly one line
	always @* begin
		strobe_d = block_strobe;
		if (call_go) begin
			strobe_d = is_erase ? blk_onehot(erase_block_select[3:0]) : 16'h0000;
		end else if (engine_end) begin
			strobe_d = 16'h0000;
		end
	end

	// Operation of the latest taken call, held for the engine
	always @* begin
		op_d = flash_op;
		if (call_taken) begin
			op_d = op_sel;
		end
	end

	// Control registers
	always @(posedge clk_sys) begin
		if (srst) begin
			state_q  <= ST_IDLE;
			flash_go <= 1'b0;
		end else begin
			state_q  <= state_d;
			flash_go <= go_d;
		end
	end

	// Data registers; cleared with the sequencer so a reset mid-call leaves no stale strobe
	always @(posedge clk_sys) begin
		if (srst) begin
			result_q     <= `FPC_RESULT_RST;
			block_strobe <= 16'h0000;
			flash_op     <= 1'b0;
		end else begin
			result_q     <= result_d;
			block_strobe <= strobe_d;
			flash_op     <= op_d;
		end
	end
endmodule // fpc_param_check

//--- src/fpc_regs.vh
`ifndef FPC_REGS_VH
`define FPC_REGS_VH
// Result byte field positions
`define FPC_BIT_SUCCESS_FAIL   0
`define FPC_BIT_DEST_ADDR_ERR  1
`define FPC_BIT_WDATA_ADDR_ERR 2
`define FPC_BIT_EXEC_ERR       5
`define FPC_BIT_MODE_ERR       6
// Result reset value
`define FPC_RESULT_RST         8'h00
// Flash area bounds, inclusive (plain defaults)
`define FPC_FLASH_LO           32'h00000000
`define FPC_FLASH_HI           32'h0001FFFF
// Programming unit alignment: low byte must be one of these
`define FPC_ALIGN_A            8'h00
`define FPC_ALIGN_B            8'h80
// Highest erase block number
`define FPC_LAST_BLOCK         16'h000F
// Operation codes
`define FPC_OP_PROGRAM         1'b0
`define FPC_OP_ERASE           1'b1
`endif
